// *** verilog/pif_pkg.sv ***
// Package for the peripheral interrupt flag block: register map, fields, reset values
package pif_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets on the plain register port)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W          = 8;              // Address width
    localparam int unsigned DATA_W          = 8;              // Data width of every register
    localparam logic [7:0]  OFS_TOP_CTRL    = 8'h00;          // Global enable and peripheral gate
    localparam logic [7:0]  OFS_ENABLE_1    = 8'h01;          // Enables for the first flag register
    localparam logic [7:0]  OFS_ENABLE_2    = 8'h02;          // Enables for the second flag register
    localparam logic [7:0]  OFS_FLAGS_1     = 8'h03;          // Serial, capture and timer flags
    localparam logic [7:0]  OFS_FLAGS_2     = 8'h04;          // Protection and converter flags

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_GLOBAL_EN   = 7;              // global_irq_enable
    localparam int unsigned BIT_PERIPH_GATE = 6;              // peripheral_irq_gate
    localparam int unsigned BIT_TX_EMPTY    = 7;              // tx_buffer_empty_flag
    localparam int unsigned BIT_RX_FULL     = 6;              // rx_buffer_full_flag
    localparam int unsigned BIT_UNUSED_2    = 5;              // Unimplemented bit of set 2

    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  TOP_CTRL_MASK   = 8'hC0;          // Implemented control bits
    localparam logic [7:0]  SET2_MASK       = 8'hDF;          // Bit 5 absent in set 2
    localparam logic [7:0]  FLAGS1_SW_MASK  = 8'h3F;          // Software-writable flags of set 1
    localparam logic [7:0]  REG_RESET       = 8'h00;          // Every register resets to zero

    // ------------------------------------------------------------
    // Register port request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic              wr;                                // Write strobe
        logic              rd;                                // Read strobe
        logic [ADDR_W-1:0] addr;                              // Register address
        logic [DATA_W-1:0] wdata;                             // Write data
    } pif_bus_req_t;

endpackage : pif_pkg

// *** verilog/pif_periph_irq.sv ***
// Peripheral interrupt enable and flag registers with the gated interrupt request
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module pif_periph_irq #(
    parameter int unsigned DATA_W = pif_pkg::DATA_W           // Register width
) (
    input  wire logic                 clk,                    // 125 MHz system clock
    input  wire logic                 rst_n,                  // Asynchronous reset, active low
    input  wire pif_pkg::pif_bus_req_t bus_req,               // Register port request
    output logic [DATA_W-1:0]         rdata,                  // Read data, cycle after strobe
    input  wire logic [DATA_W-1:0]    flags1_evt,             // Event pulses for flag set 1
    input  wire logic [DATA_W-1:0]    flags2_evt,             // Event pulses for flag set 2
    input  wire logic                 tx_data_written,        // Pulse: transmit data reg written
    input  wire logic                 rx_data_read,           // Pulse: receive data reg read
    output logic                      periph_irq              // Gated peripheral request
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DATA_W != 8) begin : g_bad_width
        $error("pif_periph_irq supports only 8-bit registers");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_ff,    nxt_ctrl;                  // Global enable and gate
    logic [DATA_W-1:0] en1_ff,     nxt_en1;                   // Enable set 1
    logic [DATA_W-1:0] en2_ff,     nxt_en2;                   // Enable set 2
    logic [DATA_W-1:0] flg1_ff,    nxt_flg1;                  // Flag set 1
    logic [DATA_W-1:0] flg2_ff,    nxt_flg2;                  // Flag set 2
    logic [DATA_W-1:0] rdata_ff,   nxt_rdata;                 // Read data register
    logic              irq_ff,     nxt_irq;                   // Interrupt request register

    // Address match, used by both the write and read paths
    function automatic logic hit(input logic [pif_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == pif_pkg::ADDR_W'(ofs));
    endfunction : hit

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [DATA_W-1:0] sw1;                               // Flags 1 after software write
        logic [DATA_W-1:0] sw2;                               // Flags 2 after software write
        logic              pend;                              // Any unmasked flag
        pend      = 1'b0;
        nxt_ctrl  = ctrl_ff;
        nxt_en1   = en1_ff;
        nxt_en2   = en2_ff;
        sw1       = flg1_ff;
        sw2       = flg2_ff;
        nxt_rdata = '0;
        // Register writes
        if (bus_req.wr) begin
            if (hit(bus_req.addr, pif_pkg::OFS_TOP_CTRL)) begin
                nxt_ctrl = bus_req.wdata & pif_pkg::TOP_CTRL_MASK;
            end
            if (hit(bus_req.addr, pif_pkg::OFS_ENABLE_1)) begin
                nxt_en1 = bus_req.wdata;
            end
            if (hit(bus_req.addr, pif_pkg::OFS_ENABLE_2)) begin
                nxt_en2 = bus_req.wdata & pif_pkg::SET2_MASK;
            end
            // Software may set or clear bits 5:0 of set 1; the tx and rx buffer flags (bits 7, 6) keep their value
            if (hit(bus_req.addr, pif_pkg::OFS_FLAGS_1)) begin
                sw1 = (flg1_ff & ~pif_pkg::FLAGS1_SW_MASK)
                    | (bus_req.wdata & pif_pkg::FLAGS1_SW_MASK);
            end
            if (hit(bus_req.addr, pif_pkg::OFS_FLAGS_2)) begin
                sw2 = bus_req.wdata & pif_pkg::SET2_MASK;
            end
        end
        // Buffer flags clear on the data register accesses
        if (tx_data_written) begin
            sw1[pif_pkg::BIT_TX_EMPTY] = 1'b0;
        end
        if (rx_data_read) begin
            sw1[pif_pkg::BIT_RX_FULL] = 1'b0;
        end
        // Events set flags whatever the enables; the set wins
        nxt_flg1 = sw1 | flags1_evt;
        nxt_flg2 = (sw2 | flags2_evt) & pif_pkg::SET2_MASK;
        // Read path
        if (bus_req.rd) begin
            unique case (1'b1)
                hit(bus_req.addr, pif_pkg::OFS_TOP_CTRL): nxt_rdata = ctrl_ff;
                hit(bus_req.addr, pif_pkg::OFS_ENABLE_1): nxt_rdata = en1_ff;
                hit(bus_req.addr, pif_pkg::OFS_ENABLE_2): nxt_rdata = en2_ff;
                hit(bus_req.addr, pif_pkg::OFS_FLAGS_1):  nxt_rdata = flg1_ff;
                hit(bus_req.addr, pif_pkg::OFS_FLAGS_2):  nxt_rdata = flg2_ff;
                default:                                  nxt_rdata = '0;
            endcase
        end
        // Request from current flags and enables, every cycle
        pend    = |((flg1_ff & en1_ff) | (flg2_ff & en2_ff));
        nxt_irq = pend
                & ctrl_ff[pif_pkg::BIT_PERIPH_GATE]
                & ctrl_ff[pif_pkg::BIT_GLOBAL_EN];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff  <= pif_pkg::REG_RESET;
            en1_ff   <= pif_pkg::REG_RESET;
            en2_ff   <= pif_pkg::REG_RESET;
            flg1_ff  <= pif_pkg::REG_RESET;
            flg2_ff  <= pif_pkg::REG_RESET;
            rdata_ff <= pif_pkg::REG_RESET;
            irq_ff   <= 1'b0;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            en1_ff   <= nxt_en1;
            en2_ff   <= nxt_en2;
            flg1_ff  <= nxt_flg1;
            flg2_ff  <= nxt_flg2;
            rdata_ff <= nxt_rdata;
            irq_ff   <= nxt_irq;
        end
    end

    assign rdata      = rdata_ff;
    assign periph_irq = irq_ff;

endmodule : pif_periph_irq

`default_nettype wire

// *** sim/pif_chk.sv ***
// Checker for the peripheral interrupt flag block
`timescale 1ns/1ns
`default_nettype none
module pif_chk (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire pif_pkg::pif_bus_req_t bus_req,
    input wire logic [7:0]            rdata,
    input wire logic [7:0]            flags1_evt,
    input wire logic [7:0]            flags2_evt,
    input wire logic                  tx_data_written,
    input wire logic                  rx_data_read,
    input wire logic                  periph_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] ctl_ff;  // Shadow of top control
    logic [7:0] en2_ff;  // Shadow of enable set 2
    // Track software writes to the gates and enable set 2
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= 8'h00;
            en2_ff <= 8'h00;
        end else if (bus_req.wr) begin
            if (bus_req.addr == 8'h00) ctl_ff <= bus_req.wdata;
            if (bus_req.addr == 8'h02) en2_ff <= bus_req.wdata;
        end
    end
    sequence s_rd(logic [7:0] a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    property p_b5;
        bus_req.rd && (bus_req.addr == 8'h02 || bus_req.addr == 8'h04) |=> rdata[5] == 1'b0;
    endproperty
    property p_ev2;
        flags2_evt != 8'h00 ##1 s_rd(8'h04)
        |=> (rdata & $past(flags2_evt, 2)) == ($past(flags2_evt, 2) & 8'hDF);
    endproperty
    property p_ev1;
        (flags1_evt & 8'h3F) != 8'h00 ##1 s_rd(8'h03)
        |=> (rdata & $past(flags1_evt, 2) & 8'h3F) == ($past(flags1_evt, 2) & 8'h3F);
    endproperty
    property p_tx;
        tx_data_written && !flags1_evt[7] ##1 s_rd(8'h03) |=> !rdata[7];
    endproperty
    property p_rx;
        rx_data_read && !flags1_evt[6] ##1 s_rd(8'h03) |=> !rdata[6];
    endproperty
    property p_glob;
        !ctl_ff[7] |=> !periph_irq;
    endproperty
    property p_gate;
        !ctl_ff[6] |=> !periph_irq;
    endproperty
    property p_irq;
        flags2_evt[0] && en2_ff[0] && ctl_ff[7:6] == 2'b11 && !bus_req.wr ##1 !bus_req.wr
        |=> periph_irq;
    endproperty
    a_b5: assert property (p_b5) else $error("bit 5 read nonzero");
    a_ev2: assert property (p_ev2) else $error("flag set 2 missed");
    a_ev1: assert property (p_ev1) else $error("flag set 1 missed");
    a_tx: assert property (p_tx) else $error("tx flag not cleared");
    a_rx: assert property (p_rx) else $error("rx flag not cleared");
    a_glob: assert property (p_glob) else $error("irq without global");
    a_gate: assert property (p_gate) else $error("irq without gate");
    a_irq: assert property (p_irq) else $error("irq missing");
endmodule : pif_chk
bind pif_periph_irq pif_chk chk_u (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .rdata(rdata), .flags1_evt(flags1_evt), .flags2_evt(flags2_evt),
    .tx_data_written(tx_data_written), .rx_data_read(rx_data_read), .periph_irq(periph_irq));
`default_nettype wire

// *** sim/pif_evt_src.sv ***
// Peripheral event source model: one-cycle pulses on request
`timescale 1ns/1ns
`default_nettype none
module pif_evt_src (
    input  wire logic [17:0] req,
    input  wire logic        clk,
    input  wire logic        rst_n,
    output logic [17:0]      evt
);
    // Each event lasts one clock, as a timer match or rollover does
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) evt <= '0;
        else evt <= req;
    end
endmodule : pif_evt_src
`default_nettype wire

// *** sim/pif_periph_irq_bench.sv ***
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ns
`default_nettype none
module pif_periph_irq_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pif_pkg::pif_bus_req_t bus = '0;
    logic [17:0] req = '0;
    logic [17:0] evt;
    logic [7:0] rdata;
    logic irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    pif_evt_src src_u (.req(req), .clk(clk), .rst_n(rst_n), .evt(evt));
    pif_periph_irq dut_u (.clk(clk), .rst_n(rst_n), .bus_req(bus), .rdata(rdata),
        .flags1_evt(evt[17:10]), .flags2_evt(evt[9:2]), .tx_data_written(evt[1]),
        .rx_data_read(evt[0]), .periph_irq(irq));
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        bus <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        bus <= '0;
        #1 chk("rdata", e, rdata);
        @(posedge clk);
    endtask : rd
    task ev(input logic [17:0] r);
        req <= r;
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : ev
    task ichk(input logic e);
        #1 chk("irq", {7'h00, e}, {7'h00, irq});
        @(posedge clk);
    endtask : ichk
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    // Bound the run in case the bus hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 6; a++) rd(a[7:0], 8'h00);
        wr(8'h02, 8'hFF);
        rd(8'h02, 8'hDF);
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'hDF);
        wr(8'h09, 8'hFF);
        rd(8'h09, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h04, 8'h00);
        $display("test access done");
        ev({8'hFF, 8'hFF, 2'b00});
        rd(8'h03, 8'hFF);
        rd(8'h04, 8'hDF);
        ichk(1'b0);
        ev({16'h0000, 2'b10});
        rd(8'h03, 8'h7F);
        ev({16'h0000, 2'b01});
        rd(8'h03, 8'h3F);
        wr(8'h03, 8'h00);
        rd(8'h03, 8'h00);
        req <= {8'h02, 10'h000};
        @(posedge clk);
        req <= '0;
        wr(8'h03, 8'h00);
        rd(8'h03, 8'h02);
        $display("test flags done");
        wr(8'h00, 8'hC0);
        wr(8'h02, 8'h04);
        wr(8'h04, 8'h00);
        ev({8'h00, 8'h01, 2'b00});
        @(posedge clk);
        ichk(1'b0);
        wr(8'h02, 8'h05);
        ichk(1'b1);
        wr(8'h00, 8'h80);
        ichk(1'b0);
        wr(8'h00, 8'hC0);
        ichk(1'b1);
        wr(8'h04, 8'h00);
        ichk(1'b0);
        ev({8'h00, 8'h01, 2'b00});
        @(posedge clk);
        ichk(1'b1);
        $display("test irq done");
        conclude();
    end
endmodule : pif_periph_irq_bench
`default_nettype wire
